// ==== pkg/pbat_pkg.sv ====
// Purpose: Shared constants and types of the peripheral bus access timing bridge
// Assumes: One core clock; peripheral clock exists only as a tick derived here
// Notes:   Target map and per-target cycle counts live here
package pbat_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int PBAT_ADDR_W = 16;
    localparam int PBAT_DATA_W = 32;
    localparam int PBAT_CNT_W = 4;
    localparam int PBAT_DIV_W = 3;
    localparam int PBAT_LEN_W = 8;

    // ------------------------------------------------------------
    // Timing counts
    // ------------------------------------------------------------
    localparam logic [PBAT_CNT_W-1:0] PBAT_MAIN_CYCLES = 4'h1;
    localparam logic [PBAT_CNT_W-1:0] PBAT_CYC_BUS1 = 4'h1;
    localparam logic [PBAT_CNT_W-1:0] PBAT_CYC_BERR = 4'h1;
    localparam logic [PBAT_CNT_W-1:0] PBAT_CYC_EXTB = 4'h2;
    localparam logic [PBAT_CNT_W-1:0] PBAT_CYC_BUS2 = 4'h2;
    localparam logic [PBAT_CNT_W-1:0] PBAT_CYC_BUS3 = 4'h2;
    localparam logic [PBAT_CNT_W-1:0] PBAT_CYC_BUS4 = 4'h3;
    localparam logic [PBAT_CNT_W-1:0] PBAT_CYC_BUS5 = 4'h4;
    localparam logic [PBAT_CNT_W-1:0] PBAT_CYC_BUS6 = 4'h5;

    // ------------------------------------------------------------
    // Target decode: field position and codes
    // ------------------------------------------------------------
    localparam int PBAT_TGT_LSB = 12;
    localparam logic [3:0] PBAT_TGT_BUS1 = 4'h0;
    localparam logic [3:0] PBAT_TGT_BERR = 4'h1;
    localparam logic [3:0] PBAT_TGT_EXTB = 4'h2;
    localparam logic [3:0] PBAT_TGT_BUS2 = 4'h3;
    localparam logic [3:0] PBAT_TGT_BUS3 = 4'h4;
    localparam logic [3:0] PBAT_TGT_BUS4 = 4'h5;
    localparam logic [3:0] PBAT_TGT_BUS5 = 4'h6;
    localparam logic [3:0] PBAT_TGT_BUS6 = 4'h7;

    typedef enum logic [1:0] {PBAT_IDLE, PBAT_MAIN, PBAT_SYNC, PBAT_PERI} pbat_state_t;

    typedef struct packed {
        logic needs_sync;
        logic [PBAT_CNT_W-1:0] cycles;
    } pbat_target_t;
endpackage

// ==== pkg/pbat_tick_if.sv ====
// Purpose: Carries the peripheral clock tick and its divide ratio
// Assumes: Both ends on clk_i
// Notes:   shift is log2 of core cycles per peripheral cycle
`timescale 1ns/1ns
interface pbat_tick_if;
    logic [2:0] shift;
    logic tick;
    modport gen (input shift, output tick);
    modport user (output shift, input tick);
endinterface

// ==== design/pbat_tick_gen.sv ====
// Purpose: Free-running divided peripheral clock tick
// Assumes: shift changes only between accesses
// Notes:   tick marks the core cycle holding a peripheral clock edge
`timescale 1ns/1ns
module pbat_tick_gen
    import pbat_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    pbat_tick_if.gen tk
);
    typedef struct packed {
        logic [6:0] cnt;
        logic tick;
    } pbat_tick_st_t;

    pbat_tick_st_t st;
    pbat_tick_st_t next_st;
    logic [6:0] last;

    always_comb begin
        last = 7'(7'h01 << tk.shift) - 7'h01;
        next_st = st;
        next_st.tick = (st.cnt == last);
        next_st.cnt = (st.cnt >= last) ? 7'h00 : st.cnt + 7'h01;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tk.tick = st.tick;
endmodule

// ==== design/pbat_bridge.sv ====
// Purpose: Main bus to peripheral bus bridge that times register accesses
// Assumes: Divider codes are log2 divisors of one source clock, held stable
// Notes:   Ack is a one-cycle pulse; busy_o stalls the master until then
`timescale 1ns/1ns
module pbat_bridge
    import pbat_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [PBAT_ADDR_W-1:0] addr_i,
    input wire logic [PBAT_DATA_W-1:0] wdata_i,
    input wire logic [PBAT_DIV_W-1:0] core_div_i,
    input wire logic [PBAT_DIV_W-1:0] per_div_i,
    input wire logic xfer_ctl_busy_i,
    input wire logic [PBAT_DATA_W-1:0] prdata_i,
    output logic busy_o,
    output logic ack_o,
    output logic [PBAT_DATA_W-1:0] rdata_o,
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [PBAT_ADDR_W-1:0] paddr_o,
    output logic [PBAT_DATA_W-1:0] pwdata_o
);
    // ------------------------------------------------------------
    // Target decode
    // ------------------------------------------------------------
    function automatic pbat_target_t decode(input logic [PBAT_ADDR_W-1:0] a);
        pbat_target_t t;
        t.needs_sync = 1'b1;
        t.cycles = PBAT_CYC_BUS2;
        case (a[PBAT_TGT_LSB +: 4])
            PBAT_TGT_BUS1: begin
                t = '{needs_sync: 1'b0, cycles: PBAT_CYC_BUS1};
            end
            PBAT_TGT_BERR: begin
                t = '{needs_sync: 1'b0, cycles: PBAT_CYC_BERR};
            end
            PBAT_TGT_EXTB: t.cycles = PBAT_CYC_EXTB;
            PBAT_TGT_BUS3: t.cycles = PBAT_CYC_BUS3;
            PBAT_TGT_BUS4: t.cycles = PBAT_CYC_BUS4;
            PBAT_TGT_BUS5: t.cycles = PBAT_CYC_BUS5;
            PBAT_TGT_BUS6: t.cycles = PBAT_CYC_BUS6;
            default: t.cycles = PBAT_CYC_BUS2;
        endcase
        return t;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        pbat_state_t state;
        logic slow;
        logic [PBAT_CNT_W-1:0] cnt;
        logic [PBAT_CNT_W-1:0] cyc;
        logic busy;
        logic ack;
        logic [PBAT_DATA_W-1:0] rdata;
        logic psel;
        logic penable;
        logic pwrite;
        logic [PBAT_ADDR_W-1:0] paddr;
        logic [PBAT_DATA_W-1:0] pwdata;
    } pbat_bridge_st_t;

    pbat_bridge_st_t st;
    pbat_bridge_st_t next_st;
    pbat_target_t tgt;
    logic core_ge;
    logic step;

    pbat_tick_if tk ();

    pbat_tick_gen u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tk(tk)
    );

    // Peripheral clock ratio relative to the core; zero when the core is slower
    assign core_ge = (core_div_i <= per_div_i);
    assign tk.shift = core_ge ? 3'(per_div_i - core_div_i) : 3'h0;
    assign tgt = decode(addr_i);
    // Slow accesses advance on peripheral edges, others on core cycles
    assign step = st.slow ? tk.tick : 1'b1;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.ack = 1'b0;
        next_st.penable = 1'b0;
        case (st.state)
            PBAT_IDLE: begin
                // Transfer controller owns the bus: hold off, timing stretches
                if (req_i && !xfer_ctl_busy_i) begin
                    next_st.state = PBAT_MAIN;
                    next_st.busy = 1'b1;
                    next_st.slow = tgt.needs_sync && core_ge;
                    next_st.cyc = tgt.cycles;
                    next_st.cnt = tgt.cycles;
                    next_st.pwrite = we_i;
                    next_st.paddr = addr_i;
                    next_st.pwdata = wdata_i;
                end
            end
            PBAT_MAIN: begin
                // An edge inside the main bus cycle leaves no sync to add
                if (st.slow && !tk.tick) begin
                    next_st.state = PBAT_SYNC;
                end else begin
                    next_st.state = PBAT_PERI;
                    next_st.psel = 1'b1;
                    next_st.penable = (st.cnt == 4'h1) && !st.slow;
                end
            end
            PBAT_SYNC: begin
                if (tk.tick) begin
                    next_st.state = PBAT_PERI;
                    next_st.psel = 1'b1;
                end
            end
            PBAT_PERI: begin
                if (step) begin
                    if (st.cnt == 4'h1) begin
                        next_st.state = PBAT_IDLE;
                        next_st.psel = 1'b0;
                        next_st.busy = 1'b0;
                        next_st.ack = 1'b1;
                        next_st.rdata = st.pwrite ? st.rdata : prdata_i;
                    end else begin
                        next_st.cnt = st.cnt - 4'h1;
                        next_st.penable = (st.cnt == 4'h2) && !st.slow;
                    end
                end else begin
                    next_st.penable = st.penable;
                end
            end
            default: begin
                next_st.state = PBAT_IDLE;
                next_st.psel = 1'b0;
                next_st.busy = 1'b0;
            end
        endcase
        // Slow mode commits when the next edge comes; strobe the final period
        if (st.slow && st.state != PBAT_IDLE && next_st.state == PBAT_PERI && next_st.cnt == 4'h1) begin
            next_st.penable = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '{state: PBAT_IDLE, default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign busy_o = st.busy;
    assign ack_o = st.ack;
    assign rdata_o = st.rdata;
    assign psel_o = st.psel;
    assign penable_o = st.penable;
    assign pwrite_o = st.pwrite;
    assign paddr_o = st.paddr;
    assign pwdata_o = st.pwdata;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [PBAT_LEN_W-1:0] acc_len;
    logic [PBAT_LEN_W-1:0] sync_len;
    always_ff @(posedge clk_i) begin
        if (rst_i || st.state == PBAT_IDLE) begin
            acc_len <= '0;
            sync_len <= '0;
        end else begin
            acc_len <= acc_len + 8'h01;
            if (st.state != PBAT_PERI) begin
                sync_len <= sync_len + 8'h01;
            end
        end
    end

    sequence s_taken;
        st.state == PBAT_IDLE && req_i && !xfer_ctl_busy_i;
    endsequence
    sequence s_blocked;
        st.state == PBAT_IDLE && xfer_ctl_busy_i;
    endsequence

    contention_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_blocked |=> st.state == PBAT_IDLE && !busy_o)
        else $error("access started while transfer controller held the bus");
    fast_length_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st.state == PBAT_PERI && !st.slow && next_st.ack) |-> acc_len + 8'h01 == 8'(PBAT_MAIN_CYCLES + st.cyc))
        else $error("core-cycle access length differs from main plus peripheral cycles");
    sync_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st.state == PBAT_SYNC |-> sync_len < 8'(8'h01 << tk.shift))
        else $error("main plus sync cycles exceed one peripheral clock");
    no_sync_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st.state == PBAT_SYNC |-> st.slow)
        else $error("sync cycles added to an unsynchronised target");
    sync_exit_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st.state == PBAT_SYNC && tk.tick) |=> st.state == PBAT_PERI)
        else $error("sync not ended by peripheral edge");
    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |-> !busy_o && !psel_o ##1 !ack_o)
        else $error("ack not a single cycle after release");
    stall_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_taken |=> busy_o && !ack_o ##1 busy_o)
        else $error("master not stalled after acceptance");
    next_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ack_o && req_i && !xfer_ctl_busy_i) |=> st.state == PBAT_MAIN)
        else $error("next access not started the cycle after completion");
    read_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st.state == PBAT_PERI && next_st.ack && !st.pwrite) |=> rdata_o == $past(prdata_i))
        else $error("read data not captured at completion");
endmodule

// ==== sim/pbat_periph_model.sv ====
// Purpose: Peripheral register block model on the far side of the bridge
// Assumes: Read data needed only while select and commit strobe are high
// Notes:   Outside a read commit the data bus churns, so stale data cannot pass
`timescale 1ns/1ns
module pbat_periph_model
    import pbat_pkg::*;
(
    input wire logic clk_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [PBAT_ADDR_W-1:0] paddr_i,
    input wire logic [PBAT_DATA_W-1:0] pwdata_i,
    output logic [PBAT_DATA_W-1:0] prdata_o
);
    // Keyed by target only: the bench uses one register per target
    logic [PBAT_DATA_W-1:0] mem [16];
    logic [15:0] written = 16'h0000;
    logic [PBAT_DATA_W-1:0] junk = 32'h5a5a0f0f;

    always @(posedge clk_i) begin
        junk <= {junk[30:0], junk[31] ^ junk[21] ^ junk[1] ^ junk[0]};
        if (psel_i && penable_i && pwrite_i) begin
            mem[paddr_i[PBAT_TGT_LSB +: 4]] <= pwdata_i;
            written[paddr_i[PBAT_TGT_LSB +: 4]] <= 1'b1;
        end
    end

    always @* begin
        prdata_o = junk;
        if (psel_i && penable_i && !pwrite_i && written[paddr_i[PBAT_TGT_LSB +: 4]]) begin
            prdata_o = mem[paddr_i[PBAT_TGT_LSB +: 4]];
        end
    end
endmodule

// ==== sim/testbench.sv ====
// Purpose: Self-checking bench for the peripheral bus access timing bridge
// Assumes: Latency counted in edges from the taking edge to the ack cycle
// Notes:   Slow-mode sync is phase dependent, so only its bounds are checked
`timescale 1ns/1ns
module testbench;
    import pbat_pkg::*;
    typedef struct {logic we; int tgt; logic [2:0] cd; logic [2:0] pd; int len;} pbat_row_t;
    localparam logic [3:0] CYC [8] = '{PBAT_CYC_BUS1, PBAT_CYC_BERR, PBAT_CYC_EXTB, PBAT_CYC_BUS2,
                                      PBAT_CYC_BUS3, PBAT_CYC_BUS4, PBAT_CYC_BUS5, PBAT_CYC_BUS6};
    logic clk_i = 1'b0, rst_i = 1'b1, req_i = 1'b0, we_i = 1'b0, xfer_ctl_busy_i = 1'b0;
    logic [15:0] addr_i = 16'h0000;
    logic [31:0] wdata_i = 32'h00000000, prdata_i, rdata_o, pwdata_o, rd;
    logic [2:0] core_div_i = 3'h1, per_div_i = 3'h1;
    logic busy_o, ack_o, psel_o, penable_o, pwrite_o;
    logic [15:0] paddr_o;
    int failures = 0, total_checks = 0, n;
    pbat_row_t rows [16];

    pbat_bridge uut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .we_i(we_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .core_div_i(core_div_i), .per_div_i(per_div_i), .xfer_ctl_busy_i(xfer_ctl_busy_i),
        .prdata_i(prdata_i), .busy_o(busy_o), .ack_o(ack_o), .rdata_o(rdata_o), .psel_o(psel_o),
        .penable_o(penable_o), .pwrite_o(pwrite_o), .paddr_o(paddr_o), .pwdata_o(pwdata_o));
    pbat_periph_model far (.clk_i(clk_i), .psel_i(psel_o), .penable_i(penable_o), .pwrite_i(pwrite_o),
        .paddr_i(paddr_o), .pwdata_i(pwdata_o), .prdata_o(prdata_i));

    always #5 clk_i = ~clk_i;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Counts edges after the taking edge until ack shows
    task automatic wait_ack(output int cnt);
        cnt = 0;
        do begin
            @(posedge clk_i);
            #1;
            cnt++;
            if (cnt == 1) check(busy_o, 1'b1);
        end while (ack_o !== 1'b1 && cnt < 60);
        check(ack_o, 1'b1);
        check(busy_o, 1'b0);
        rd = rdata_o;
    endtask

    // Hold-off cycles model the transfer controller owning the bus
    task automatic access(input logic we, input int t, input int hold, input logic keep, output int cnt);
        @(posedge clk_i);
        req_i <= 1'b1;
        we_i <= we;
        addr_i <= {t[3:0], 12'h0a4};
        wdata_i <= {16'hc0de, 8'h00, t[7:0]} ^ {32{~we}};
        xfer_ctl_busy_i <= (hold > 0);
        for (int i = 0; i < hold; i++) begin
            @(posedge clk_i);
            if (i == hold - 1) xfer_ctl_busy_i <= 1'b0;
            #1;
            check({ack_o, busy_o, psel_o}, 3'b000);
        end
        @(posedge clk_i);
        req_i <= keep;
        wait_ack(cnt);
        check({pwrite_o, paddr_o}, {we, t[3:0], 12'h0a4});
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        for (int t = 0; t < 8; t++) begin
            rows[2 * t] = '{1'b1, t, 3'h1, 3'h1, PBAT_MAIN_CYCLES + CYC[t]};
            rows[2 * t + 1] = '{1'b0, t, 3'h2, 3'h0, PBAT_MAIN_CYCLES + CYC[t]};
        end
        repeat (5) @(posedge clk_i);
        #1;
        check({busy_o, ack_o, psel_o, penable_o}, 4'h0);
        @(posedge clk_i);
        rst_i <= 1'b0;
        // Write then read back the last written register
        foreach (rows[i]) begin
            @(posedge clk_i);
            core_div_i <= rows[i].cd;
            per_div_i <= rows[i].pd;
            access(rows[i].we, rows[i].tgt, 0, 1'b0, n);
            check(n, rows[i].len);
            if (!rows[i].we) check(rd, {16'hc0de, 8'h00, 8'(rows[i].tgt)});
        end
        access(1'b0, 2, 4, 1'b0, n);
        check(n, PBAT_MAIN_CYCLES + CYC[2]);
        // Back to back: second read taken in the ack cycle of the first
        access(1'b0, 7, 0, 1'b1, n);
        @(posedge clk_i);
        req_i <= 1'b0;
        wait_ack(n);
        check(n, PBAT_MAIN_CYCLES + CYC[7]);
        check(rd, 32'hc0de0007);
        // Unlisted target falls back to bus 2 timing
        access(1'b0, 9, 0, 1'b0, n);
        check(n, PBAT_MAIN_CYCLES + PBAT_CYC_BUS2);
        // Slow core-relative mode, start phase swept by idle gaps
        @(posedge clk_i);
        core_div_i <= 3'h0;
        per_div_i <= 3'h2;
        for (int t = 0; t < 8; t++) begin
            for (int g = 0; g < 4; g++) begin
                repeat (g) @(posedge clk_i);
                access(1'b0, t, 0, 1'b0, n);
                if (t < 2) check(n, PBAT_MAIN_CYCLES + CYC[t]);
                else check(n > 4 * CYC[t] && n <= 4 * CYC[t] + 4, 1'b1);
                check(rd, {16'hc0de, 8'h00, 8'(t)});
            end
        end
        // Reset in mid access drops busy, ack, select and enable
        @(posedge clk_i);
        req_i <= 1'b1;
        addr_i <= 16'h7000;
        @(posedge clk_i);
        req_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b1;
        @(posedge clk_i);
        #1;
        check({busy_o, ack_o, psel_o, penable_o}, 4'h0);
        @(posedge clk_i);
        rst_i <= 1'b0;
        access(1'b0, 4, 0, 1'b0, n);
        check(rd, 32'hc0de0004);
        end_of_test();
    end

    initial begin
        #60000;
        failures++;
        end_of_test();
    end
endmodule
